// ---- src/gauge_pkg.sv ----
package gauge_pkg;

   // two-wire bus address; arbitrary value, no maker meaning
   localparam logic [6:0]  DEV_ADDR        = 7'h36;
   localparam logic [3:0]  BYTE_BITS       = 4'h8;

   // register offsets
   localparam logic [7:0]  REG_ALERT_FLAGS = 8'h00;
   localparam logic [7:0]  REG_CHARGE_PCT  = 8'h06;
   localparam logic [7:0]  REG_CELL_V      = 8'h09;
   localparam logic [7:0]  REG_CURRENT     = 8'h0A;
   localparam logic [7:0]  REG_AVG_CURRENT = 8'h0B;
   localparam logic [7:0]  REG_FULL_CAP    = 8'h10;
   localparam logic [7:0]  REG_TTE         = 8'h11;
   localparam logic [7:0]  REG_CYCLES      = 8'h17;
   localparam logic [7:0]  REG_AVG_CELL_V  = 8'h19;
   localparam logic [7:0]  REG_V_EXT       = 8'h1B;
   localparam logic [7:0]  REG_I_EXT       = 8'h1C;
   localparam logic [7:0]  REG_TTF         = 8'h20;

   // reset values
   localparam logic [15:0] FLAGS_RST       = 16'h8082;
   localparam logic [15:0] V_EXT_RST       = 16'h00FF;
   localparam logic [15:0] I_EXT_RST       = 16'h807F;
   localparam logic [15:0] ZERO_WORD       = 16'h0000;
   localparam logic [15:0] WORD_MAX        = 16'hFFFF;

   // flag bit positions
   localparam int          POR_BIT         = 1;
   localparam int          BST_BIT         = 3;
   localparam int          DSOC_BIT        = 7;
   localparam int          BI_BIT          = 11;
   localparam int          BR_BIT          = 15;
   localparam logic [15:0] FLAGS_UNDEF     = 16'h0031;
   localparam logic [15:0] FLAGS_BST_MASK  = 16'h0008;

   // limit pairs: current, voltage, temperature, charge
   localparam int          NUM_LIM         = 4;
   localparam int          LIM_CUR         = 0;
   localparam int          LIM_VOLT        = 1;
   localparam int          LIM_TEMP        = 2;
   localparam int          LIM_SOC         = 3;
   localparam logic [3:0]  LIM_SIGNED      = 4'h5;
   localparam int          LOW_BIT  [NUM_LIM] = '{2, 8, 9, 10};
   localparam int          HIGH_BIT [NUM_LIM] = '{6, 12, 13, 14};

   // measurement scaling
   localparam int          AVG_SHIFT       = 4;
   localparam logic [18:0] MULTI_NUM       = 19'h00005;
   localparam logic signed [17:0] CUR_POS_LIM = 18'sh07FFF;
   localparam logic signed [17:0] CUR_NEG_LIM = -18'sh08000;
   localparam logic [15:0] CUR_MAX         = 16'h7FFF;
   localparam logic [15:0] CUR_MIN         = 16'h8000;

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WLO, ST_WHI, ST_READ} link_state_t;

endpackage : gauge_pkg

// ---- src/serial_reg_port.sv ----
`timescale 1ns/1ps
module serial_reg_port (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        scl_raw,
   input  wire logic        sda_raw,
   output logic             sda_oe,
   output logic [7:0]       reg_addr,
   input  wire logic [15:0] reg_rdata,
   output logic             reg_wr,
   output logic [7:0]       reg_waddr,
   output logic [15:0]      reg_wdata
);
   import gauge_pkg::*;

   logic              scl_meta_ff, scl_ff, scl_d_ff;
   logic              sda_meta_ff, sda_ff, sda_d_ff;
   link_state_t       st_ff;
   logic [3:0]        bits_ff;
   logic [7:0]        sh_ff;
   logic              ack_ff, mack_ff, oe_ff, hi_ff, wr_ff;
   logic [7:0]        ptr_ff, wlo_ff, waddr_ff;
   logic [15:0]       word_ff, wdata_ff;

   // two-flop sync on both lines
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_meta_ff <= 1'b1;
         scl_ff      <= 1'b1;
         scl_d_ff    <= 1'b1;
         sda_meta_ff <= 1'b1;
         sda_ff      <= 1'b1;
         sda_d_ff    <= 1'b1;
      end else begin
         scl_meta_ff <= scl_raw;
         scl_ff      <= scl_meta_ff;
         scl_d_ff    <= scl_ff;
         sda_meta_ff <= sda_raw;
         sda_ff      <= sda_meta_ff;
         sda_d_ff    <= sda_ff;
      end
   end

   wire       scl_rise  = scl_ff & ~scl_d_ff;
   wire       scl_fall  = ~scl_ff & scl_d_ff;
   wire       bus_start = scl_ff & scl_d_ff & sda_d_ff & ~sda_ff;
   wire       bus_stop  = scl_ff & scl_d_ff & ~sda_d_ff & sda_ff;
   wire       byte_done = (bits_ff == BYTE_BITS);
   wire       addr_hit  = (sh_ff[7:1] == DEV_ADDR);
   // low byte goes first, so the word is latched then
   wire [7:0] rd_byte   = hi_ff ? word_ff[15:8] : reg_rdata[7:0];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff    <= ST_IDLE;
         bits_ff  <= 4'h0;
         sh_ff    <= 8'h00;
         ack_ff   <= 1'b0;
         mack_ff  <= 1'b0;
         oe_ff    <= 1'b0;
         hi_ff    <= 1'b0;
         wr_ff    <= 1'b0;
         ptr_ff   <= 8'h00;
         wlo_ff   <= 8'h00;
         waddr_ff <= 8'h00;
         word_ff  <= 16'h0000;
         wdata_ff <= 16'h0000;
      end else begin
         wr_ff <= 1'b0;
         if (bus_start) begin
            st_ff   <= ST_ADDR;
            bits_ff <= 4'h0;
            ack_ff  <= 1'b0;
            mack_ff <= 1'b0;
            oe_ff   <= 1'b0;
         end else if (bus_stop) begin
            st_ff   <= ST_IDLE;
            ack_ff  <= 1'b0;
            mack_ff <= 1'b0;
            oe_ff   <= 1'b0;
         end else if (st_ff != ST_IDLE) begin
            if (scl_rise) begin
               if (mack_ff) begin
                  // a not-acknowledge ends the read
                  if (sda_ff) begin
                     st_ff   <= ST_IDLE;
                     mack_ff <= 1'b0;
                  end
               end else if (!ack_ff) begin
                  bits_ff <= bits_ff + 4'h1;
                  if (st_ff != ST_READ) begin
                     sh_ff <= {sh_ff[6:0], sda_ff};
                  end
               end
            end else if (scl_fall) begin
               if (ack_ff || mack_ff) begin
                  ack_ff  <= 1'b0;
                  mack_ff <= 1'b0;
                  bits_ff <= 4'h0;
                  oe_ff   <= 1'b0;
                  if (st_ff == ST_READ) begin
                     oe_ff <= ~rd_byte[7];
                     sh_ff <= {rd_byte[6:0], 1'b0};
                     hi_ff <= ~hi_ff;
                     if (!hi_ff) begin
                        word_ff <= reg_rdata;
                     end else begin
                        ptr_ff <= ptr_ff + 8'h01;
                     end
                  end
               end else if (byte_done) begin
                  if (st_ff == ST_READ) begin
                     oe_ff   <= 1'b0;
                     mack_ff <= 1'b1;
                  end else begin
                     ack_ff <= 1'b1;
                     oe_ff  <= 1'b1;
                     unique case (st_ff)
                        ST_ADDR: begin
                           hi_ff <= 1'b0;
                           if (addr_hit) begin
                              st_ff <= sh_ff[0] ? ST_READ : ST_PTR;
                           end else begin
                              st_ff  <= ST_IDLE;
                              ack_ff <= 1'b0;
                              oe_ff  <= 1'b0;
                           end
                        end
                        ST_PTR: begin
                           ptr_ff <= sh_ff;
                           st_ff  <= ST_WLO;
                        end
                        ST_WLO: begin
                           wlo_ff <= sh_ff;
                           st_ff  <= ST_WHI;
                        end
                        ST_WHI: begin
                           wr_ff    <= 1'b1;
                           waddr_ff <= ptr_ff;
                           wdata_ff <= {sh_ff, wlo_ff};
                           ptr_ff   <= ptr_ff + 8'h01;
                           st_ff    <= ST_WLO;
                        end
                        ST_IDLE, ST_READ: begin
                           oe_ff <= 1'b0;
                        end
                     endcase
                  end
               end else if (st_ff == ST_READ) begin
                  oe_ff <= ~sh_ff[7];
                  sh_ff <= {sh_ff[6:0], 1'b0};
               end
            end
         end
      end
   end

   assign sda_oe    = oe_ff;
   assign reg_addr  = ptr_ff;
   assign reg_wr    = wr_ff;
   assign reg_waddr = waddr_ff;
   assign reg_wdata = wdata_ff;

endmodule : serial_reg_port

// ---- src/gauge_status_and_measurement_regs.sv ----
`timescale 1ns/1ps
// Summary of operation
// RQ1 - power-on flag set at any reset, host clears
// RQ2 - current below/above limits sets bits 2/6
// RQ3 - voltage below/above limits sets bits 8/12
// RQ4 - temperature below/above limits sets bits 9/13
// RQ5 - charge below/above limits sets bits 10/14
// RQ6 - bit 3 shows battery absent
// RQ7 - whole-percent charge change sets bit 7
// RQ8 - insertion sets bit 11, host clears
// RQ9 - removal sets bit 15, also at power-up
// RQ10 - bits 0, 4, 5 undefined; read zero
// RQ11 - cell voltage: 2.5x sense or pack supply
// RQ12 - voltage extremes peak/lowest bytes, reset 00FF
// RQ13 - host write 00FF restarts voltage tracking
// RQ14 - current is saturated two's complement
// RQ15 - current extremes reset 807F, host restarts
// RQ16 - cycle count in 1% steps, saturating
// RQ17 - time to empty valid while current negative
// RQ18 - time to full valid while current positive
// RQ19 - full capacity reloaded at charge end
// RQ20 - averages follow successive readings
// RQ21 - each limit pair sticky or self-clearing
// RQ22 - current extremes are signed bytes
// RQ23 - each update replaces exceeded extreme byte
// RQ24 - host write stores flags; hardware set wins
module gauge_status_and_measurement_regs (
   input  wire logic               MCLK,
   input  wire logic               RESET,
   input  wire logic               SCL,
   input  wire logic               SDA_IN,
   output logic                    SDA_OUT,
   output logic                    SDA_OE,
   input  wire logic               MEAS_UPDATE,
   input  wire logic [15:0]        CELL_SENSE,
   input  wire logic [15:0]        PACK_SUPPLY,
   input  wire logic               MULTI_CELL,
   input  wire logic signed [17:0] SENSE_VOLTAGE,
   input  wire logic signed [7:0]  TEMPERATURE,
   input  wire logic [15:0]        CHARGE_PERCENT,
   input  wire logic [15:0]        CURRENT_LIMIT_PAIR,
   input  wire logic [15:0]        VOLTAGE_LIMIT_PAIR,
   input  wire logic [15:0]        TEMPERATURE_LIMIT_PAIR,
   input  wire logic [15:0]        CHARGE_LIMIT_PAIR,
   input  wire logic [3:0]         LIMIT_AUTO_CLEAR,
   input  wire logic               BATTERY_PRESENT,
   input  wire logic               INSERT_EVENT,
   input  wire logic               REMOVE_EVENT,
   input  wire logic               SOFT_POR,
   input  wire logic               CHARGE_END,
   input  wire logic [15:0]        FULL_CAP_ESTIMATE,
   input  wire logic [15:0]        TTE_ESTIMATE,
   input  wire logic [15:0]        TTF_ESTIMATE,
   input  wire logic               CYCLE_STEP,
   output logic [15:0]             FLAGS
);
   import gauge_pkg::*;

   logic [7:0]  rd_addr;
   logic [15:0] rd_data;
   logic        wr_stb;
   logic [7:0]  wr_addr;
   logic [15:0] wr_data;

   logic [15:0] alert_flags_ff, nxt_alert_flags;
   logic [15:0] charge_pct_ff;
   logic [15:0] cell_voltage_ff, nxt_cell_voltage;
   logic [15:0] avg_cell_v_ff, nxt_avg_cell_v;
   logic [15:0] current_ff, nxt_current;
   logic [15:0] avg_current_ff, nxt_avg_current;
   logic [15:0] v_ext_ff, nxt_v_ext;
   logic [15:0] i_ext_ff, nxt_i_ext;
   logic [15:0] full_cap_ff;
   logic [15:0] tte_ff;
   logic [15:0] ttf_ff;
   logic [15:0] cycles_ff;
   logic        bst_ff;

   serial_reg_port u_port (
      .clk       (MCLK),
      .rst       (RESET),
      .scl_raw   (SCL),
      .sda_raw   (SDA_IN),
      .sda_oe    (SDA_OE),
      .reg_addr  (rd_addr),
      .reg_rdata (rd_data),
      .reg_wr    (wr_stb),
      .reg_waddr (wr_addr),
      .reg_wdata (wr_data)
   );

   // open drain: the pin is only ever pulled low
   assign SDA_OUT = 1'b0;

   // ---- measurement scaling
   // 2.5x as times five, halved
   wire [18:0] multi_scaled = ({3'b000, CELL_SENSE} * MULTI_NUM) >> 1;
   wire [15:0] multi_sat    = (multi_scaled[18:16] != 3'b000) ? WORD_MAX : multi_scaled[15:0];
   assign nxt_cell_voltage  = MULTI_CELL ? multi_sat : PACK_SUPPLY; // RQ11

   // clamp at the register ends
   wire cur_over  = (SENSE_VOLTAGE > CUR_POS_LIM);
   wire cur_under = (SENSE_VOLTAGE < CUR_NEG_LIM);
   assign nxt_current = cur_over  ? CUR_MAX :
                        cur_under ? CUR_MIN : SENSE_VOLTAGE[15:0]; // RQ14

   // averages: arithmetic shift keeps the sign
   wire signed [16:0] v_diff = $signed({1'b0, nxt_cell_voltage}) - $signed({1'b0, avg_cell_v_ff});
   wire signed [16:0] i_diff = $signed({nxt_current[15], nxt_current})
                             - $signed({avg_current_ff[15], avg_current_ff});
   wire signed [16:0] v_step = v_diff >>> AVG_SHIFT;
   wire signed [16:0] i_step = i_diff >>> AVG_SHIFT;
   assign nxt_avg_cell_v  = avg_cell_v_ff + v_step[15:0]; // RQ20
   assign nxt_avg_current = avg_current_ff + i_step[15:0]; // RQ20

   // byte views
   // upper bytes: voltage in 20 mV steps
   wire [7:0] v_byte   = nxt_cell_voltage[15:8];
   wire [7:0] i_byte   = nxt_current[15:8];
   wire [7:0] soc_byte = CHARGE_PERCENT[15:8];

   logic [7:0]  lim_val   [NUM_LIM];
   logic [15:0] lim_pair  [NUM_LIM];
   logic [3:0]  below_lim;
   logic [3:0]  above_lim;

   assign lim_val[LIM_CUR]   = i_byte;
   assign lim_val[LIM_VOLT]  = v_byte;
   assign lim_val[LIM_TEMP]  = TEMPERATURE;
   assign lim_val[LIM_SOC]   = soc_byte;
   assign lim_pair[LIM_CUR]  = CURRENT_LIMIT_PAIR;
   assign lim_pair[LIM_VOLT] = VOLTAGE_LIMIT_PAIR;
   assign lim_pair[LIM_TEMP] = TEMPERATURE_LIMIT_PAIR;
   assign lim_pair[LIM_SOC]  = CHARGE_LIMIT_PAIR;

   // pair: max in upper byte, min in lower
   genvar g;
   generate
      for (g = 0; g < NUM_LIM; g++) begin : g_lim
         wire [8:0] val_k = {LIM_SIGNED[g] & lim_val[g][7], lim_val[g]};
         wire [8:0] min_k = {LIM_SIGNED[g] & lim_pair[g][7], lim_pair[g][7:0]};
         wire [8:0] max_k = {LIM_SIGNED[g] & lim_pair[g][15], lim_pair[g][15:8]};
         assign below_lim[g] = $signed(val_k) < $signed(min_k); // RQ2 RQ3 RQ4 RQ5
         assign above_lim[g] = $signed(val_k) > $signed(max_k); // RQ2 RQ3 RQ4 RQ5
      end
   endgenerate

   // ---- status flags
   wire soc_step = MEAS_UPDATE && (soc_byte != charge_pct_ff[15:8]);

   always_comb begin
      nxt_alert_flags = alert_flags_ff;
      if (wr_stb && (wr_addr == REG_ALERT_FLAGS)) begin
         // host writes store, so writing zero clears a flag
         nxt_alert_flags = (wr_data & ~(FLAGS_UNDEF | FLAGS_BST_MASK))
                         | (alert_flags_ff & FLAGS_BST_MASK); // RQ24
      end
      if (MEAS_UPDATE) begin
         for (int k = 0; k < NUM_LIM; k++) begin
            if (LIMIT_AUTO_CLEAR[k]) begin
               nxt_alert_flags[LOW_BIT[k]]  = below_lim[k]; // RQ21
               nxt_alert_flags[HIGH_BIT[k]] = above_lim[k]; // RQ21
            end else begin
               nxt_alert_flags[LOW_BIT[k]]  = nxt_alert_flags[LOW_BIT[k]] | below_lim[k];
               nxt_alert_flags[HIGH_BIT[k]] = nxt_alert_flags[HIGH_BIT[k]] | above_lim[k];
            end
         end
      end
      // hardware sets come last so they beat a clearing write
      if (soc_step) begin
         nxt_alert_flags[DSOC_BIT] = 1'b1; // RQ7 RQ24
      end
      if (INSERT_EVENT) begin
         nxt_alert_flags[BI_BIT] = 1'b1; // RQ8 RQ24
      end
      if (REMOVE_EVENT) begin
         nxt_alert_flags[BR_BIT] = 1'b1; // RQ9 RQ24
      end
      if (SOFT_POR) begin
         nxt_alert_flags[POR_BIT] = 1'b1; // RQ1 RQ24
      end
      nxt_alert_flags[BST_BIT] = bst_ff; // RQ6
      nxt_alert_flags = nxt_alert_flags & ~FLAGS_UNDEF; // RQ10
   end

   // reset sets power-on, charge-change, removal
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         alert_flags_ff <= FLAGS_RST; // RQ1 RQ7 RQ9
         bst_ff         <= 1'b0; // RQ6
      end else begin
         alert_flags_ff <= nxt_alert_flags;
         bst_ff         <= ~BATTERY_PRESENT; // RQ6
      end
   end

   // extremes: a write restarts tracking
   wire        v_ext_wr = wr_stb && (wr_addr == REG_V_EXT);
   wire        i_ext_wr = wr_stb && (wr_addr == REG_I_EXT);
   wire [15:0] v_base   = v_ext_wr ? wr_data : v_ext_ff; // RQ13
   wire [15:0] i_base   = i_ext_wr ? wr_data : i_ext_ff; // RQ15

   wire v_new_peak = (v_byte > v_base[15:8]);
   wire v_new_low  = (v_byte < v_base[7:0]);
   wire i_new_peak = ($signed(i_byte) > $signed(i_base[15:8])); // RQ22
   wire i_new_low  = ($signed(i_byte) < $signed(i_base[7:0])); // RQ22

   assign nxt_v_ext = MEAS_UPDATE ? {v_new_peak ? v_byte : v_base[15:8],
                                     v_new_low  ? v_byte : v_base[7:0]} : v_base; // RQ23
   assign nxt_i_ext = MEAS_UPDATE ? {i_new_peak ? i_byte : i_base[15:8],
                                     i_new_low  ? i_byte : i_base[7:0]} : i_base; // RQ23

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         v_ext_ff <= V_EXT_RST; // RQ12
         i_ext_ff <= I_EXT_RST; // RQ15
      end else begin
         v_ext_ff <= nxt_v_ext;
         i_ext_ff <= nxt_i_ext;
      end
   end

   // ---- measurement and report registers
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         charge_pct_ff   <= ZERO_WORD;
         cell_voltage_ff <= ZERO_WORD;
         avg_cell_v_ff   <= ZERO_WORD;
         current_ff      <= ZERO_WORD;
         avg_current_ff  <= ZERO_WORD;
         tte_ff          <= ZERO_WORD;
         ttf_ff          <= ZERO_WORD;
      end else if (MEAS_UPDATE) begin
         charge_pct_ff   <= CHARGE_PERCENT;
         cell_voltage_ff <= nxt_cell_voltage; // RQ11
         avg_cell_v_ff   <= nxt_avg_cell_v; // RQ20
         current_ff      <= nxt_current; // RQ14
         avg_current_ff  <= nxt_avg_current; // RQ20
         // stored every update; meaning depends on current sign
         tte_ff          <= TTE_ESTIMATE; // RQ17
         ttf_ff          <= TTF_ESTIMATE; // RQ18
      end
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         full_cap_ff <= ZERO_WORD;
      end else if (CHARGE_END) begin
         full_cap_ff <= FULL_CAP_ESTIMATE; // RQ19
      end
   end

   // 1% per count; holds at the top
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         cycles_ff <= ZERO_WORD;
      end else if (CYCLE_STEP && (cycles_ff != WORD_MAX)) begin
         cycles_ff <= cycles_ff + 16'h0001; // RQ16
      end
   end

   // ---- read decode; unmapped offsets answer zero
   function automatic logic [15:0] read_word(input logic [7:0] addr);
      unique case (addr)
         REG_ALERT_FLAGS: read_word = alert_flags_ff & ~FLAGS_UNDEF; // RQ10
         REG_CHARGE_PCT:  read_word = charge_pct_ff;
         REG_CELL_V:      read_word = cell_voltage_ff;
         REG_CURRENT:     read_word = current_ff;
         REG_AVG_CURRENT: read_word = avg_current_ff;
         REG_FULL_CAP:    read_word = full_cap_ff;
         REG_TTE:         read_word = tte_ff;
         REG_CYCLES:      read_word = cycles_ff;
         REG_AVG_CELL_V:  read_word = avg_cell_v_ff;
         REG_V_EXT:       read_word = v_ext_ff;
         REG_I_EXT:       read_word = i_ext_ff;
         REG_TTF:         read_word = ttf_ff;
         default:         read_word = ZERO_WORD;
      endcase
   endfunction : read_word

   always_comb rd_data = read_word(rd_addr);
   assign FLAGS   = alert_flags_ff;

endmodule : gauge_status_and_measurement_regs

// ---- tb/gauge_regs_sva.sv ----
`timescale 1ns/1ps
module gauge_regs_sva
   import gauge_pkg::*;
(
   input wire logic               MCLK,
   input wire logic               RESET,
   input wire logic               MEAS_UPDATE,
   input wire logic [15:0]        PACK_SUPPLY,
   input wire logic               MULTI_CELL,
   input wire logic signed [17:0] SENSE_VOLTAGE,
   input wire logic [15:0]        CHARGE_PERCENT,
   input wire logic [15:0]        CURRENT_LIMIT_PAIR,
   input wire logic [15:0]        VOLTAGE_LIMIT_PAIR,
   input wire logic [15:0]        CHARGE_LIMIT_PAIR,
   input wire logic               BATTERY_PRESENT,
   input wire logic               INSERT_EVENT,
   input wire logic               REMOVE_EVENT,
   input wire logic               SOFT_POR,
   input wire logic [15:0]        FLAGS
);
   // saturated current byte
   logic signed [7:0] cur_hi;
   assign cur_hi = (SENSE_VOLTAGE > CUR_POS_LIM) ? 8'sh7F :
                   (SENSE_VOLTAGE < CUR_NEG_LIM) ? 8'sh80 : SENSE_VOLTAGE[15:8];
   default clocking @(posedge MCLK); endclocking
   default disable iff (RESET);
   // checked while reset held
   property p_rst; disable iff (1'b0) RESET |-> FLAGS == 16'h8082; endproperty
   property p_por; SOFT_POR |=> FLAGS[1]; endproperty
   property p_cur; MEAS_UPDATE && cur_hi < $signed(CURRENT_LIMIT_PAIR[7:0]) |=> FLAGS[2];
   endproperty
   property p_volt; MEAS_UPDATE && !MULTI_CELL && PACK_SUPPLY[15:8] < VOLTAGE_LIMIT_PAIR[7:0]
      |=> FLAGS[8]; endproperty
   property p_soc; MEAS_UPDATE && CHARGE_PERCENT[15:8] > CHARGE_LIMIT_PAIR[15:8] |=> FLAGS[14];
   endproperty
   property p_bst; !$past(RESET, 2) |-> FLAGS[3] == !$past(BATTERY_PRESENT, 2); endproperty
   property p_ins; INSERT_EVENT |=> FLAGS[11]; endproperty
   property p_rem; REMOVE_EVENT |=> FLAGS[15]; endproperty
   a_rst: assert property (p_rst) else $error("flags reset value");
   a_por: assert property (p_por) else $error("power-on flag");
   a_cur: assert property (p_cur) else $error("current low flag");
   a_volt: assert property (p_volt) else $error("voltage low flag");
   a_soc: assert property (p_soc) else $error("charge high flag");
   a_bst: assert property (p_bst) else $error("absent bit");
   a_ins: assert property (p_ins) else $error("inserted flag");
   a_rem: assert property (p_rem) else $error("removed flag");
   c_upd: cover property (MEAS_UPDATE ##1 FLAGS[14]);
   c_evt: cover property (INSERT_EVENT && REMOVE_EVENT);
   c_abs: cover property ($fell(BATTERY_PRESENT));
endmodule : gauge_regs_sva
bind gauge_status_and_measurement_regs gauge_regs_sva i_gauge_regs_sva (.*);

// ---- tb/serial_host_model.sv ----
`timescale 1ns/1ps
module serial_host_model
   import gauge_pkg::*;
(
   input  wire logic MCLK,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   // clock stands high outside frames
   initial {scl, sda_low} = 2'b10;
   task automatic w(input int n);
      repeat (n) @(posedge MCLK);
   endtask : w
   // start when s=1, stop when s=0
   task automatic cond(input logic s);
      logic x;
      bit_io(s, x);
      sda_low <= s;
      w(4);
   endtask : cond
   // sample late, past sync lag
   task automatic bit_io(input logic b, output logic r);
      scl <= 1'b0;
      w(2);
      sda_low <= !b;
      w(2);
      scl <= 1'b1;
      w(3);
      #1 r = sda;
      w(1);
   endtask : bit_io
   task automatic byte_io(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                          output logic ak_rx);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(ak, ak_rx);
   endtask : byte_io
   task automatic wr(input logic [7:0] p, input logic [15:0] d, output logic ok);
      logic [7:0] x;
      logic a0, a1, a2, a3;
      cond(1'b1);
      byte_io({DEV_ADDR, 1'b0}, 1'b1, x, a0);
      byte_io(p, 1'b1, x, a1);
      byte_io(d[7:0], 1'b1, x, a2);
      byte_io(d[15:8], 1'b1, x, a3);
      cond(1'b0);
      ok = !(a0 | a1 | a2 | a3);
   endtask : wr
   task automatic rd(input logic [7:0] p, output logic [15:0] d, output logic ok);
      logic [7:0] x;
      logic a0, a1, a2, a3;
      cond(1'b1);
      byte_io({DEV_ADDR, 1'b0}, 1'b1, x, a0);
      byte_io(p, 1'b1, x, a1);
      cond(1'b1);
      byte_io({DEV_ADDR, 1'b1}, 1'b1, x, a2);
      byte_io(8'hFF, 1'b0, d[7:0], a3);
      byte_io(8'hFF, 1'b1, d[15:8], a3);
      cond(1'b0);
      ok = !(a0 | a1 | a2);
   endtask : rd
endmodule : serial_host_model

// ---- tb/test_gauge_status_and_measurement_regs.sv ----
`timescale 1ns/1ps
module test_gauge_status_and_measurement_regs;
   import gauge_pkg::*;
   logic mclk, reset, scl, host_low, sda_oe, upd, multi, present, ins, rem, por, chg_end, cyc;
   logic [15:0] cell_s, pack, chg, cur_lp, volt_lp, temp_lp, chg_lp, fcap, time_to_empty, time_to_full, flags, rdat;
   logic signed [17:0] sense;
   logic signed [7:0]  temp;
   logic [3:0]         auto_clr;
   int                 mismatches, checks_done;
   wire                sda = !(host_low | sda_oe);
   gauge_status_and_measurement_regs i_gauge_status_and_measurement_regs (.MCLK(mclk),
      .RESET(reset), .SCL(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe), .MEAS_UPDATE(upd),
      .CELL_SENSE(cell_s), .PACK_SUPPLY(pack), .MULTI_CELL(multi), .SENSE_VOLTAGE(sense),
      .TEMPERATURE(temp), .CHARGE_PERCENT(chg), .CURRENT_LIMIT_PAIR(cur_lp),
      .VOLTAGE_LIMIT_PAIR(volt_lp), .TEMPERATURE_LIMIT_PAIR(temp_lp),
      .CHARGE_LIMIT_PAIR(chg_lp), .LIMIT_AUTO_CLEAR(auto_clr), .BATTERY_PRESENT(present),
      .INSERT_EVENT(ins), .REMOVE_EVENT(rem), .SOFT_POR(por), .CHARGE_END(chg_end),
      .FULL_CAP_ESTIMATE(fcap), .TTE_ESTIMATE(time_to_empty), .TTF_ESTIMATE(time_to_full), .CYCLE_STEP(cyc),
      .FLAGS(flags));
   serial_host_model i_serial_host_model (.MCLK(mclk), .sda(sda), .scl(scl), .sda_low(host_low));
   always #12.5 mclk = ~mclk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] p, input logic [15:0] exp,
                      input logic [15:0] m = 16'hFFFF);
      logic ok;
      i_serial_host_model.rd(p, rdat, ok);
      chk({15'h0, ok}, 16'h0001);
      chk(rdat & m, exp);
   endtask : rdc
   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      logic ok;
      i_serial_host_model.wr(p, d, ok);
      chk({15'h0, ok}, 16'h0001);
   endtask : wr
   task automatic meas(input logic [15:0] p, input logic signed [17:0] s,
                       input logic signed [7:0] t, input logic [15:0] c);
      @(posedge mclk);
      {pack, chg, upd} <= {p, c, 1'b1};
      {sense, temp} <= {s, t};
      @(posedge mclk);
      upd <= 1'b0;
      @(posedge mclk);
   endtask : meas
   task automatic t_power_up;
      rdc(REG_ALERT_FLAGS, 16'h8082, ~FLAGS_UNDEF);
      rdc(REG_V_EXT, 16'h00FF);
      rdc(REG_I_EXT, 16'h807F);
      rdc(8'h05, 16'h0000);
   endtask : t_power_up
   task automatic t_limits;
      wr(REG_ALERT_FLAGS, 16'h0000);
      chk(flags, 16'h0000);
      {cur_lp, volt_lp, temp_lp, chg_lp} <= {16'h4000, 16'hF030, 16'h3C00, 16'h6410};
      meas(16'h2800, -18'sh01000, -8'sd5, 16'h0500);
      chk(flags, 16'h0784);
      auto_clr <= 4'hF;
      meas(16'hF800, 18'sh05000, 8'sd70, 16'h7000);
      chk(flags, 16'h70C0);
   endtask : t_limits
   task automatic t_events;
      wr(REG_ALERT_FLAGS, 16'h0000);
      {por, ins, rem, present} <= 4'hE;
      @(posedge mclk);
      {por, ins, rem} <= 3'h0;
      repeat (2) @(posedge mclk);
      chk(flags, 16'h880A);
      rdc(REG_ALERT_FLAGS, 16'h880A, ~FLAGS_UNDEF);
      present <= 1'b1;
   endtask : t_events
   task automatic t_measure;
      wr(REG_V_EXT, 16'h00FF);
      wr(REG_I_EXT, 16'h807F);
      meas(16'h3C00, 18'sh10000, 8'sd20, 16'h3000);
      rdc(REG_V_EXT, 16'h3C3C);
      rdc(REG_CURRENT, 16'h7FFF);
      {multi, cell_s} <= {1'b1, 16'h1000};
      meas(16'h0000, -18'sh20000, 8'sd20, 16'h3000);
      rdc(REG_CELL_V, 16'h2800);
      rdc(REG_V_EXT, 16'h3C28);
      rdc(REG_I_EXT, 16'h7F80);
      {fcap, chg_end, cyc} <= {16'h1234, 2'h3};
      @(posedge mclk);
      {chg_end, cyc} <= 2'h0;
      rdc(REG_FULL_CAP, 16'h1234);
      wr(REG_CYCLES, 16'hFFFF);
      rdc(REG_CYCLES, 16'h0001);
   endtask : t_measure
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   initial begin
      {mclk, reset, present} = 3'b011;
      {upd, multi, ins, rem, por, chg_end, cyc, auto_clr, sense, temp} = '0;
      {cell_s, pack, chg, cur_lp, volt_lp, temp_lp, chg_lp, fcap, time_to_empty, time_to_full} = '0;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      repeat (3) @(posedge mclk);
      t_power_up;
      t_limits;
      t_events;
      t_measure;
      test_done;
   end
   initial begin
      repeat (100000) @(posedge mclk);
      mismatches++;
      test_done;
   end
endmodule : test_gauge_status_and_measurement_regs
